// ---- hw/flc_defs.svh ----
`ifndef FLC_DEFS_SVH
`define FLC_DEFS_SVH
`define FLC_CMD_LOCK_SETUP 8'h60
`define FLC_CMD_OTP_SETUP 8'hC0
`define FLC_CMD_LOCK_CONFIRM 8'h01
`define FLC_CMD_LOCKDOWN_CONFIRM 8'h2F
`define FLC_CMD_SET_CONFIG_CONFIRM 8'h03
`define FLC_CMD_READ_ARRAY 8'hFF
`define FLC_CMD_READ_STATUS 8'h70
`define FLC_CMD_READ_SIGNATURE 8'h90
`define FLC_CMD_READ_QUERY 8'h98
`define FLC_CMD_PROGRAM_SETUP 8'h40
`define FLC_CMD_BUFFER_SETUP 8'hE8
`define FLC_CMD_CLEAR_STATUS 8'h50
`define FLC_NUM_BANKS 16
`define FLC_BANK_W 4
`define FLC_BLOCK_W 8
`define FLC_COUNT_W 5
`endif

// ---- hw/flc_pkg.sv ----
`default_nettype none
`include "flc_defs.svh"
package flc_pkg;
    typedef enum logic [1:0] {
        FLC_OUT_ARRAY,
        FLC_OUT_STATUS,
        FLC_OUT_SIGNATURE,
        FLC_OUT_QUERY
    } flc_out_t;
    typedef enum logic [1:0] {
        FLC_IN_DATA,
        FLC_IN_BLOCK_ADDR,
        FLC_IN_ILLEGAL
    } flc_kind_t;
    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [`FLC_BANK_W-1:0] bank;
        logic [`FLC_BLOCK_W-1:0] block;
        flc_kind_t kind;
    } flc_cmd_t;
endpackage
`default_nettype wire

// ---- hw/flc_bank_mode.sv ----
`default_nettype none
`include "flc_defs.svh"
module flc_bank_mode #(
    parameter int NUM_BANKS = `FLC_NUM_BANKS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic set_valid,
    input wire logic [`FLC_BANK_W-1:0] set_bank,
    input wire flc_pkg::flc_out_t set_mode,
    input wire logic [`FLC_BANK_W-1:0] read_bank,
    output var flc_pkg::flc_out_t read_mode
);
    import flc_pkg::*;
    flc_out_t mode_reg [NUM_BANKS];
    flc_out_t mode_next [NUM_BANKS];
    flc_out_t read_next;

    always_comb begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            mode_next[i] = mode_reg[i];
            if (set_valid && set_bank == i[`FLC_BANK_W-1:0]) begin
                mode_next[i] = set_mode;
            end
        end
        read_next = mode_reg[read_bank];
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (reset) begin
                mode_reg[i] <= FLC_OUT_ARRAY;
            end else begin
                mode_reg[i] <= mode_next[i];
            end
        end
        if (reset) begin
            read_mode <= FLC_OUT_ARRAY;
        end else begin
            read_mode <= read_next;
        end
    end

    sequence s_other_bank_cmd;
        set_valid && set_bank != read_bank ##1 $stable(read_bank);
    endsequence
    property p_other_bank_kept;
        @(posedge ref_clk) disable iff (reset)
        s_other_bank_cmd |-> $stable(mode_reg[read_bank]);
    endproperty
    a_other_bank_kept: assert property (p_other_bank_kept)
        else $error("Command to another bank changed the output state.");
endmodule
`default_nettype wire

// ---- hw/flc_command_state.sv ----
`default_nettype none
`include "flc_defs.svh"
// Function
// - Every bank keeps its own output state chosen by its last command.
// - The output state applies only when the read bank matches the command bank.
// - A bank's output state changes only on a command to that bank.
// - After reset every bank shows array data.
// - Array read to a busy bank gives undefined data.
// - With the controller active, both cycles of an illegal command are ignored.
// - Ready takes 60h to lock setup, C0h to OTP setup, 40h to program setup, E8h to buffer setup, else stays ready.
// - Buffer program fails if a loaded word hits another block, and always fails on the confirm cycle.
module flc_command_state (
    input wire logic ref_clk,
    input wire logic reset,
    input wire flc_pkg::flc_cmd_t cmd,
    input wire logic op_done,
    input wire logic [`FLC_BANK_W-1:0] read_bank,
    output logic controller_active,
    output logic op_start,
    output logic lock_error,
    output logic program_error,
    output logic read_undefined,
    output var flc_pkg::flc_out_t read_mode
);
    import flc_pkg::*;
    typedef enum {
        ST_READY, ST_LOCK_SETUP, ST_OTP_SETUP, ST_OTP_BUSY, ST_PROG_SETUP, ST_PROG_BUSY,
        ST_BUF_SETUP, ST_BUF_LOAD1, ST_BUF_LOAD2, ST_BUF_CONFIRM, ST_BUF_BUSY
    } flc_state_t;
    flc_state_t state_reg, state_next;
    logic [`FLC_COUNT_W-1:0] count_reg, count_next;
    logic [`FLC_BLOCK_W-1:0] block_reg, block_next;
    logic [`FLC_BANK_W-1:0] busy_bank_reg, busy_bank_next;
    logic mismatch_reg, mismatch_next;
    logic active_next, start_next, lock_err_next, prog_err_next, undef_next;
    logic mode_set;
    flc_out_t mode_val;

    function automatic logic is_busy(input flc_state_t s);
        return s == ST_OTP_BUSY || s == ST_PROG_BUSY || s == ST_BUF_BUSY;
    endfunction

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        block_next = block_reg;
        busy_bank_next = busy_bank_reg;
        mismatch_next = mismatch_reg;
        start_next = 1'b0;
        lock_err_next = lock_error;
        prog_err_next = program_error;
        mode_set = 1'b0;
        mode_val = FLC_OUT_STATUS;
        if (is_busy(state_reg) && op_done) begin
            state_next = ST_READY;
        end else if (cmd.valid) begin
            mode_set = 1'b1;
            unique case (state_reg)
                ST_READY: begin
                    if (cmd.kind != FLC_IN_DATA) begin
                        mode_set = 1'b0;
                    end else if (cmd.code == `FLC_CMD_LOCK_SETUP) begin
                        state_next = ST_LOCK_SETUP;
                    end else if (cmd.code == `FLC_CMD_OTP_SETUP) begin
                        state_next = ST_OTP_SETUP;
                    end else if (cmd.code == `FLC_CMD_PROGRAM_SETUP) begin
                        state_next = ST_PROG_SETUP;
                    end else if (cmd.code == `FLC_CMD_BUFFER_SETUP) begin
                        state_next = ST_BUF_SETUP;
                    end else if (cmd.code == `FLC_CMD_READ_ARRAY) begin
                        mode_val = FLC_OUT_ARRAY;
                    end else if (cmd.code == `FLC_CMD_READ_SIGNATURE) begin
                        mode_val = FLC_OUT_SIGNATURE;
                    end else if (cmd.code == `FLC_CMD_READ_QUERY) begin
                        mode_val = FLC_OUT_QUERY;
                    end else if (cmd.code == `FLC_CMD_CLEAR_STATUS) begin
                        lock_err_next = 1'b0;
                        prog_err_next = 1'b0;
                    end else if (cmd.code != `FLC_CMD_READ_STATUS) begin
                        mode_set = 1'b0;
                    end
                end
                ST_LOCK_SETUP: begin
                    state_next = ST_READY;
                    if (cmd.kind != FLC_IN_DATA || !(cmd.code == `FLC_CMD_LOCK_CONFIRM ||
                        cmd.code == `FLC_CMD_LOCKDOWN_CONFIRM || cmd.code == `FLC_CMD_SET_CONFIG_CONFIRM)) begin
                        lock_err_next = 1'b1;
                    end
                end
                ST_OTP_SETUP, ST_PROG_SETUP: begin
                    state_next = (state_reg == ST_OTP_SETUP) ? ST_OTP_BUSY : ST_PROG_BUSY;
                    busy_bank_next = cmd.bank;
                    start_next = 1'b1;
                end
                ST_BUF_SETUP: begin
                    count_next = cmd.code[`FLC_COUNT_W-1:0];
                    block_next = cmd.block;
                    mismatch_next = 1'b0;
                    state_next = ST_BUF_LOAD1;
                end
                ST_BUF_LOAD1: begin
                    if (cmd.kind == FLC_IN_BLOCK_ADDR) begin
                        state_next = ST_READY;
                    end else begin
                        mismatch_next = cmd.block != block_reg;
                        // The stray word fails the program at once, so the host sees it before confirming.
                        if (cmd.block != block_reg) begin
                            prog_err_next = 1'b1;
                        end
                        state_next = (count_reg == '0) ? ST_BUF_CONFIRM : ST_BUF_LOAD2;
                    end
                end
                ST_BUF_LOAD2: begin
                    count_next = count_reg - 1'b1;
                    if (cmd.block != block_reg) begin
                        mismatch_next = 1'b1;
                        prog_err_next = 1'b1;
                    end
                    if (count_reg == `FLC_COUNT_W'(1)) begin
                        state_next = ST_BUF_CONFIRM;
                    end
                end
                ST_BUF_CONFIRM: begin
                    state_next = ST_READY;
                    prog_err_next = 1'b1;
                end
                ST_OTP_BUSY, ST_PROG_BUSY, ST_BUF_BUSY: begin
                    if (cmd.kind == FLC_IN_ILLEGAL) begin
                        mode_set = 1'b0;
                    end else if (cmd.code == `FLC_CMD_READ_ARRAY) begin
                        mode_val = FLC_OUT_ARRAY;
                    end else if (cmd.code != `FLC_CMD_READ_STATUS) begin
                        mode_set = 1'b0;
                    end
                end
            endcase
        end
        if (state_reg == ST_BUF_CONFIRM && cmd.valid && mismatch_reg) begin
            prog_err_next = 1'b1;
        end
        active_next = is_busy(state_next);
        undef_next = active_next && read_bank == busy_bank_next;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= ST_READY;
            count_reg <= '0;
            block_reg <= '0;
            busy_bank_reg <= '0;
            mismatch_reg <= 1'b0;
            controller_active <= 1'b0;
            op_start <= 1'b0;
            lock_error <= 1'b0;
            program_error <= 1'b0;
            read_undefined <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            block_reg <= block_next;
            busy_bank_reg <= busy_bank_next;
            mismatch_reg <= mismatch_next;
            controller_active <= active_next;
            op_start <= start_next;
            lock_error <= lock_err_next;
            program_error <= prog_err_next;
            read_undefined <= undef_next;
        end
    end

    flc_bank_mode u_bank_mode (
        .ref_clk(ref_clk),
        .reset(reset),
        .set_valid(mode_set),
        .set_bank(cmd.bank),
        .set_mode(mode_val),
        .read_bank(read_bank),
        .read_mode(read_mode)
    );

    sequence s_lock_setup;
        cmd.valid && cmd.kind == FLC_IN_DATA && cmd.code == `FLC_CMD_LOCK_SETUP && state_reg == ST_READY;
    endsequence
    property p_ready_lock;
        @(posedge ref_clk) disable iff (reset)
        s_lock_setup |=> state_reg == ST_LOCK_SETUP;
    endproperty
    a_ready_lock: assert property (p_ready_lock)
        else $error("Lock setup code from ready did not enter lock setup.");
    sequence s_lock_bad_addr;
        state_reg == ST_LOCK_SETUP && cmd.valid && cmd.kind == FLC_IN_BLOCK_ADDR;
    endsequence
    property p_lock_err;
        @(posedge ref_clk) disable iff (reset)
        s_lock_bad_addr |=> lock_error && state_reg == ST_READY;
    endproperty
    a_lock_err: assert property (p_lock_err)
        else $error("Block address in lock setup did not flag lock error.");
    property p_busy_hold;
        @(posedge ref_clk) disable iff (reset)
        is_busy(state_reg) && !op_done |=> state_reg == $past(state_reg);
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Busy state left without completion.");
    property p_done;
        @(posedge ref_clk) disable iff (reset)
        is_busy(state_reg) && op_done |=> state_reg == ST_READY && !controller_active;
    endproperty
    a_done: assert property (p_done)
        else $error("Completion did not return to ready.");
    sequence s_load_last;
        state_reg == ST_BUF_LOAD2 && cmd.valid && count_reg == `FLC_COUNT_W'(1);
    endsequence
    property p_load2;
        @(posedge ref_clk) disable iff (reset)
        s_load_last |=> state_reg == ST_BUF_CONFIRM;
    endproperty
    a_load2: assert property (p_load2)
        else $error("Count end did not reach buffer confirm.");
    sequence s_load1_exit;
        state_reg == ST_BUF_LOAD1 && cmd.valid && cmd.kind == FLC_IN_BLOCK_ADDR;
    endsequence
    property p_exit;
        @(posedge ref_clk) disable iff (reset)
        s_load1_exit |=> state_reg == ST_READY;
    endproperty
    a_exit: assert property (p_exit)
        else $error("Block address in load 1 did not exit.");
    sequence s_stray_word;
        (state_reg == ST_BUF_LOAD2 || (state_reg == ST_BUF_LOAD1 && cmd.kind != FLC_IN_BLOCK_ADDR)) &&
            cmd.valid && cmd.block != block_reg;
    endsequence
    property p_mismatch;
        @(posedge ref_clk) disable iff (reset)
        s_stray_word |=> program_error;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("Block mismatch did not fail the buffer program.");
    property p_illegal;
        @(posedge ref_clk) disable iff (reset)
        is_busy(state_reg) && !op_done && cmd.valid && cmd.kind == FLC_IN_ILLEGAL |-> !mode_set && state_next == state_reg;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("Illegal command while active was not ignored.");
endmodule
`default_nettype wire

// ---- test/flc_host_model.sv ----
`default_nettype none
`include "flc_defs.svh"
module flc_host_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire flc_pkg::flc_cmd_t req,
    input wire logic second,
    output var flc_pkg::flc_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    import flc_pkg::*;
    logic [`FLC_BANK_W-1:0] first_bank_reg;
    flc_cmd_t cmd_next;
    always_comb begin
        cmd_next = req;
        if (second) begin
            cmd_next.bank = first_bank_reg;
        end
        // An idle bus does not keep its last code, so a stale value is never mistaken for a write.
        if (!req.valid) begin
            cmd_next.code = ~cmd.code;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd <= '0;
            first_bank_reg <= '0;
        end else begin
            cmd <= cmd_next;
            if (req.valid && !second) begin
                first_bank_reg <= req.bank;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/test_flc_command_state.sv ----
`default_nettype none
`include "flc_defs.svh"
module test_flc_command_state;
    timeunit 1ns;
    timeprecision 1ps;
    import flc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic second = 1'b0;
    logic op_done = 1'b0;
    logic [3:0] read_bank = 4'h0;
    flc_cmd_t req = '0;
    flc_cmd_t cmd;
    logic controller_active, op_start, lock_error, program_error, read_undefined;
    flc_out_t read_mode;
    int miscompares = 0;
    int n_tests = 0;
    int n_starts = 0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (op_start === 1'b1) n_starts++;
    flc_host_model host_u (.ref_clk(ref_clk), .reset(reset), .req(req), .second(second), .cmd(cmd));
    flc_command_state dut_u (.ref_clk(ref_clk), .reset(reset), .cmd(cmd), .op_done(op_done),
        .read_bank(read_bank), .controller_active(controller_active), .op_start(op_start),
        .lock_error(lock_error), .program_error(program_error), .read_undefined(read_undefined),
        .read_mode(read_mode));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [3:0] b, input flc_kind_t k, input logic s,
        input logic [7:0] blk);
        @(posedge ref_clk);
        #2;
        req = '{valid: 1'b1, code: c, bank: b, block: blk, kind: k};
        second = s;
        @(posedge ref_clk);
        #2;
        req.valid = 1'b0;
        second = 1'b0;
        repeat (3) @(posedge ref_clk);
        #2;
    endtask
    task automatic mode_is(input logic [3:0] b, input flc_out_t exp);
        read_bank = b;
        repeat (2) @(posedge ref_clk);
        #2;
        chk("read_mode", 8'(read_mode), 8'(exp));
    endtask
    task automatic finish_op();
        op_done = 1'b1;
        @(posedge ref_clk);
        #2;
        op_done = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2;
        chk("controller_active", 8'(controller_active), 8'h00);
    endtask
    task automatic t_modes();
        mode_is(4'h3, FLC_OUT_ARRAY);
        send(`FLC_CMD_READ_STATUS, 4'h3, FLC_IN_DATA, 1'b0, 8'h00);
        send(`FLC_CMD_READ_SIGNATURE, 4'h5, FLC_IN_DATA, 1'b0, 8'h00);
        send(`FLC_CMD_READ_QUERY, 4'h7, FLC_IN_DATA, 1'b0, 8'h00);
        mode_is(4'h3, FLC_OUT_STATUS);
        mode_is(4'h5, FLC_OUT_SIGNATURE);
        mode_is(4'h7, FLC_OUT_QUERY);
        mode_is(4'h9, FLC_OUT_ARRAY);
        send(`FLC_CMD_READ_ARRAY, 4'h3, FLC_IN_DATA, 1'b0, 8'h00);
        mode_is(4'h3, FLC_OUT_ARRAY);
        mode_is(4'h5, FLC_OUT_SIGNATURE);
    endtask
    task automatic t_lock();
        logic [7:0] ok_codes[3] = '{8'h01, 8'h2F, 8'h03};
        flc_kind_t bad_kind[3] = '{FLC_IN_DATA, FLC_IN_BLOCK_ADDR, FLC_IN_ILLEGAL};
        for (int i = 0; i < 3; i++) begin
            send(`FLC_CMD_LOCK_SETUP, 4'h2, FLC_IN_DATA, 1'b0, 8'h00);
            send(ok_codes[i], 4'h2, FLC_IN_DATA, 1'b1, 8'h00);
            chk("lock_error", 8'(lock_error), 8'h00);
        end
        for (int i = 0; i < 3; i++) begin
            send(`FLC_CMD_LOCK_SETUP, 4'h2, FLC_IN_DATA, 1'b0, 8'h00);
            send(`FLC_CMD_LOCK_SETUP, 4'h2, bad_kind[i], 1'b1, 8'h00);
            chk("lock_error", 8'(lock_error), 8'h01);
            send(`FLC_CMD_CLEAR_STATUS, 4'h2, FLC_IN_DATA, 1'b0, 8'h00);
            chk("lock_error", 8'(lock_error), 8'h00);
        end
    endtask
    task automatic t_busy();
        send(8'h03, 4'h1, FLC_IN_DATA, 1'b0, 8'h00);
        send(`FLC_CMD_OTP_SETUP, 4'h1, FLC_IN_DATA, 1'b0, 8'h00);
        send(8'h12, 4'h1, FLC_IN_DATA, 1'b1, 8'h00);
        chk("controller_active", 8'(controller_active), 8'h01);
        chk("op_start count", 8'(n_starts), 8'h01);
        send(8'h00, 4'h1, FLC_IN_ILLEGAL, 1'b0, 8'h00);
        chk("controller_active", 8'(controller_active), 8'h01);
        chk("lock_error", 8'(lock_error), 8'h00);
        read_bank = 4'h1;
        repeat (2) @(posedge ref_clk);
        #2;
        chk("read_undefined", 8'(read_undefined), 8'h01);
        read_bank = 4'h2;
        repeat (2) @(posedge ref_clk);
        #2;
        chk("read_undefined", 8'(read_undefined), 8'h00);
        finish_op();
        send(`FLC_CMD_PROGRAM_SETUP, 4'h4, FLC_IN_DATA, 1'b0, 8'h00);
        send(8'h34, 4'h4, FLC_IN_DATA, 1'b1, 8'h00);
        chk("op_start count", 8'(n_starts), 8'h02);
        finish_op();
    endtask
    task automatic t_buf(input int n, input logic bad);
        send(`FLC_CMD_BUFFER_SETUP, 4'h6, FLC_IN_DATA, 1'b0, 8'h11);
        send(8'(n - 1), 4'h6, FLC_IN_DATA, 1'b1, 8'h11);
        for (int i = 0; i < n; i++) begin
            send(8'(i), 4'h6, FLC_IN_DATA, 1'b0, (bad && i == 1) ? 8'h22 : 8'h11);
        end
        chk("program_error", 8'(program_error), 8'(bad));
        send(8'h00, 4'h6, FLC_IN_DATA, 1'b0, 8'h11);
        chk("program_error", 8'(program_error), 8'h01);
        send(`FLC_CMD_CLEAR_STATUS, 4'h6, FLC_IN_DATA, 1'b0, 8'h00);
    endtask
    task automatic t_exit();
        send(`FLC_CMD_BUFFER_SETUP, 4'h6, FLC_IN_DATA, 1'b0, 8'h11);
        send(8'h03, 4'h6, FLC_IN_DATA, 1'b1, 8'h11);
        send(8'h00, 4'h6, FLC_IN_BLOCK_ADDR, 1'b0, 8'h11);
        send(`FLC_CMD_OTP_SETUP, 4'h6, FLC_IN_DATA, 1'b0, 8'h00);
        send(8'h00, 4'h6, FLC_IN_DATA, 1'b1, 8'h00);
        chk("controller_active", 8'(controller_active), 8'h01);
        finish_op();
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 4000);
        miscompares++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #2;
        reset = 1'b0;
        t_modes();
        t_lock();
        t_busy();
        t_buf(4, 1'b0);
        t_buf(4, 1'b1);
        t_buf(1, 1'b0);
        t_exit();
        close_out();
    end
endmodule
`default_nettype wire
